/* File: src/watchdog_with_reset_cause.v */
// Watchdog timer with reset-cause flag register
`include "watchdog_defines.vh"
// What this block does
// - Debug-port reset sets its cause flag; power-on or written zero clears.
// - Watchdog reset sets its cause flag; power-on or written zero clears.
// - Brown-out reset sets its cause flag; power-on or written zero clears.
// - External reset sets its cause flag; power-on or written zero clears.
// - Power-on sets its flag; only a written zero clears it.
// - Time-out in interrupt behaviour sets the interrupt flag.
// - Interrupt flag clears on vector taken or written one.
// - Interrupt request needs global enable, local enable and flag.
// - Reset-enable and interrupt-enable select stopped, irq, reset or irq-then-reset.
// - In irq-then-reset, vector taken clears enable and flag.
// - In irq-then-reset, second time-out with irq pending issues system reset.
// - Clearing reset-enable or changing prescale needs change-enable set.
// - Change-enable self-clears four clocks after being written one.
// - Reset-enable forced one while watchdog cause flag is set.
// - Prescale 0 gives 2048 oscillator cycles, doubling up to code 9.
// - Programmed fuse locks reset-only behaviour.
// - Restart instruction clears counter before time-out.
// - Counter counts 128 kHz oscillator ticks.
module watchdog_with_reset_cause (
  // Clock and reset (reset is any system reset)
  input wire clk,
  input wire reset,
  // Reset cause inputs, high during that reset
  input wire powerOnReset,
  input wire debugReset,
  input wire brownoutReset,
  input wire externalReset,
  // Configuration and core signals
  input wire alwaysOnFuse,
  input wire globalIntEnable,
  input wire restartCounter,
  input wire vectorTaken,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // Outputs
  output wire timeoutIrq,
  output reg watchdogResetReq
);
  reg [4:0] cause_q;
  reg flag_q;
  reg ie_q;
  reg re_q;
  reg [3:0] ps_q;
  reg chgEn_q;
  reg [2:0] chgCnt_q;
  reg [`CNT_W-1:0] cnt_q;
  wire tick;
  wire wrCtrl = regWrite && (regAddr == `ADDR_CTRL_STATUS);
  wire wrCause = regWrite && (regAddr == `ADDR_RESET_CAUSE);

  // --------------------------------------------------------------
  // Time-out length
  // --------------------------------------------------------------
  function [`CNT_W-1:0] limit;
    input [3:0] code;
    begin
      if (code > `MAX_PRESCALE)
        limit = `BASE_TIMEOUT;
      else
        limit = `BASE_TIMEOUT << code;
    end
  endfunction

  wdt_tick_divider divider (
    .clk(clk),
    .reset(reset),
    .tick(tick)
  );

  wire effRe = alwaysOnFuse | re_q | cause_q[`BIT_WDT_RF];
  wire effIe = ie_q & ~alwaysOnFuse;
  wire running = effRe | effIe;
  wire timeout = running && tick && (cnt_q >= limit(ps_q) - 1'b1);

  // --------------------------------------------------------------
  // Counter and watchdog reset
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      cnt_q <= {`CNT_W{1'b0}};
      watchdogResetReq <= 1'b0;
    end else begin
      if (restartCounter || timeout || !running)
        cnt_q <= {`CNT_W{1'b0}};
      else if (tick)
        cnt_q <= cnt_q + 1'b1;
      watchdogResetReq <= timeout && effRe && (!effIe || flag_q);
    end
  end

  // --------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 4'h0;
      chgEn_q <= 1'b0;
      chgCnt_q <= 3'h0;
      re_q <= alwaysOnFuse | watchdogResetReq | cause_q[`BIT_WDT_RF];
    end else begin
      if (chgEn_q) begin
        if (chgCnt_q == `CHG_WINDOW_CYCLES - 1'b1) begin
          chgEn_q <= 1'b0;
          chgCnt_q <= 3'h0;
        end else begin
          chgCnt_q <= chgCnt_q + 1'b1;
        end
      end
      if (wrCtrl) begin
        ie_q <= regWrData[`BIT_TO_IE] & ~alwaysOnFuse;
        if (regWrData[`BIT_CHG_EN]) begin
          chgEn_q <= 1'b1;
          chgCnt_q <= 3'h0;
        end
        if (chgEn_q) begin
          ps_q <= {regWrData[`BIT_PS3], regWrData[2:0]};
          re_q <= regWrData[`BIT_RST_EN];
        end else if (regWrData[`BIT_RST_EN]) begin
          re_q <= 1'b1;
        end
      end else if (vectorTaken && effRe && effIe) begin
        ie_q <= 1'b0;
      end
      if (cause_q[`BIT_WDT_RF] || alwaysOnFuse)
        re_q <= 1'b1;
      // set wins, clear by vector or written one
      if (timeout && effIe)
        flag_q <= 1'b1;
      else if (vectorTaken || (wrCtrl && regWrData[`BIT_TO_FLAG]))
        flag_q <= 1'b0;
    end
  end

  assign timeoutIrq = globalIntEnable & effIe & flag_q;

  // --------------------------------------------------------------
  // Reset-cause flags (not cleared by the system reset)
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (wrCause)
      cause_q <= cause_q & regWrData[4:0];
    // power-on only set, others cleared by power-on
    if (powerOnReset)
      cause_q <= 5'h01;
    else begin
      if (debugReset)
        cause_q[`BIT_DBG_RF] <= 1'b1;
      if (watchdogResetReq)
        cause_q[`BIT_WDT_RF] <= 1'b1;
      if (brownoutReset)
        cause_q[`BIT_BO_RF] <= 1'b1;
      if (externalReset)
        cause_q[`BIT_EXT_RF] <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (reset)
      regRdData <= 8'h00;
    else if (regRead && regAddr == `ADDR_CTRL_STATUS)
      regRdData <= {flag_q, effIe, ps_q[3], chgEn_q, effRe, ps_q[2:0]};
    else if (regRead && regAddr == `ADDR_RESET_CAUSE)
      regRdData <= {3'h0, cause_q};
    else
      regRdData <= 8'h00;
  end
endmodule // watchdog_with_reset_cause

/* File: src/watchdog_defines.vh */
// Constants for the watchdog and reset-cause block
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH
// Register offsets
`define ADDR_CTRL_STATUS 8'h60
`define ADDR_RESET_CAUSE 8'h61
// Control/status field positions
`define BIT_TO_FLAG 7
`define BIT_TO_IE 6
`define BIT_PS3 5
`define BIT_CHG_EN 4
`define BIT_RST_EN 3
// Reset-cause field positions
`define BIT_DBG_RF 4
`define BIT_WDT_RF 3
`define BIT_BO_RF 2
`define BIT_EXT_RF 1
`define BIT_POR_RF 0
`define CAUSE_MASK 8'h1F
// Timing
`define CHG_WINDOW_CYCLES 3'h4
`define SYS_CLK_HZ 100000000
`define WDT_OSC_HZ 128000
`define OSC_DIV_CYCLES ((`SYS_CLK_HZ) / (`WDT_OSC_HZ))
`define OSC_DIV_W 10
`define BASE_TIMEOUT 21'h000800
`define MAX_PRESCALE 4'h9
`define CNT_W 21
`endif

/* File: src/wdt_tick_divider.v */
// Divider that makes the watchdog oscillator tick enable
`include "watchdog_defines.vh"
module wdt_tick_divider (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Tick output
  output reg tick
);
  reg [`OSC_DIV_W-1:0] divCnt_q;
  localparam integer DIV_LAST_I = `OSC_DIV_CYCLES - 1;
  localparam [`OSC_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`OSC_DIV_W-1:0];

  always @(posedge clk) begin
    if (reset) begin
      divCnt_q <= {`OSC_DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (divCnt_q == DIV_LAST) begin
      divCnt_q <= {`OSC_DIV_W{1'b0}};
      tick <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // wdt_tick_divider

/* File: verif/watchdog_with_reset_cause_monitor.sv */
// Assertions on the watchdog block ports
module watchdog_with_reset_cause_monitor (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Core inputs
  input wire alwaysOnFuse,
  input wire globalIntEnable,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  // Outputs
  input wire timeoutIrq,
  input wire watchdogResetReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rd_idle_zero_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data without a read");
  unmapped_read_a: assert property (regRead && regAddr != 8'h60 && regAddr != 8'h61
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  cause_mask_a: assert property (regRead && regAddr == 8'h61 |=> regRdData[7:5] == 3'h0)
    else $error("unused cause bits set");
  irq_gate_a: assert property (timeoutIrq |-> globalIntEnable)
    else $error("irq without global enable");
  irq_fuse_a: assert property (timeoutIrq |-> !alwaysOnFuse)
    else $error("irq with fuse programmed");
  fuse_lock_a: assert property (regRead && regAddr == 8'h60 && alwaysOnFuse
    |=> regRdData[3] && !regRdData[6]) else $error("fuse lock broken");
  chg_window_a: assert property ((regWrite && regAddr == 8'h60 && regWrData[4])
    ##1 (!regWrite && !regRead) [*6] ##1 (regRead && regAddr == 8'h60)
    |=> !regRdData[4]) else $error("change window left open");
  rst_pulse_a: assert property (watchdogResetReq |=> !watchdogResetReq)
    else $error("reset request longer than one cycle");
  cover property (regRead && regAddr == 8'h61);
  cover property (regWrite && regAddr == 8'h60 && regWrData[4]);
  cover property (regRead && alwaysOnFuse);
endmodule // watchdog_with_reset_cause_monitor

bind watchdog_with_reset_cause watchdog_with_reset_cause_monitor i_mon (.clk, .reset,
  .alwaysOnFuse, .globalIntEnable, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .timeoutIrq, .watchdogResetReq);

/* File: verif/test_watchdog_with_reset_cause.sv */
// Register-level bench for the watchdog block
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin nErrors++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module test_watchdog_with_reset_cause;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, powerOnReset = 0, debugReset = 0, brownoutReset = 0;
  logic externalReset = 0, alwaysOnFuse = 0, globalIntEnable = 0, restartCounter = 0;
  logic vectorTaken = 0, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, v;
  wire [7:0] regRdData;
  wire timeoutIrq, watchdogResetReq;
  int nErrors = 0, totalChecks = 0, cyc = 0;
  watchdog_with_reset_cause i_dut (.clk, .reset, .powerOnReset, .debugReset,
    .brownoutReset, .externalReset, .alwaysOnFuse, .globalIntEnable, .restartCounter,
    .vectorTaken, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .timeoutIrq,
    .watchdogResetReq);
  initial forever #5 clk = ~clk;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // Cause inputs as {power-on, debug, brown-out, external}
  task automatic rst(input logic [3:0] c);
    @(posedge clk);
    reset <= 1'b1;
    {powerOnReset, debugReset, brownoutReset, externalReset} <= c;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    {powerOnReset, debugReset, brownoutReset, externalReset} <= 4'h0;
  endtask
  task automatic finishTest();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nErrors++;
      finishTest();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst(4'h8);
    rd(8'h61, v); `CHK(v, 8'h01)
    rst(4'h4); rd(8'h61, v); `CHK(v, 8'h11)
    rst(4'h2); rd(8'h61, v); `CHK(v, 8'h15)
    rst(4'h1); rd(8'h61, v); `CHK(v, 8'h17)
    wr(8'h61, 8'h01); rst(4'h0); rd(8'h61, v); `CHK(v, 8'h01)
    wr(8'h61, 8'h00); rd(8'h61, v); `CHK(v, 8'h00)
    $display("test cause flags done");
    rd(8'h60, v); `CHK(v, 8'h00)
    wr(8'h60, 8'h08); wr(8'h60, 8'h07); rd(8'h60, v); `CHK(v, 8'h08)
    wr(8'h60, 8'h18); wr(8'h60, 8'h0D); rd(8'h60, v); `CHK(v, 8'h1D)
    wr(8'h60, 8'h18);
    repeat (5) @(posedge clk);
    rd(8'h60, v); `CHK(v, 8'h0D)
    wr(8'h60, 8'h00); rd(8'h60, v); `CHK(v, 8'h0D)
    @(posedge clk);
    globalIntEnable <= 1'b1;
    restartCounter <= 1'b1;
    @(posedge clk) restartCounter <= 1'b0;
    vectorTaken <= 1'b1;
    @(posedge clk) vectorTaken <= 1'b0;
    wr(8'h60, 8'h18); wr(8'h60, 8'h00); rd(8'h60, v); `CHK(v, 8'h10)
    `CHK(timeoutIrq, 1'b0)
    rd(8'h62, v); `CHK(v, 8'h00)
    $display("test control done");
    @(posedge clk) alwaysOnFuse <= 1'b1;
    rst(4'h0);
    wr(8'h60, 8'h40); rd(8'h60, v); `CHK(v & 8'h48, 8'h08)
    $display("test fuse done");
    finishTest();
  end
endmodule // test_watchdog_with_reset_cause
